// *** dv/cfg_regs_bench.sv ***
// self-checking bench for the register bank
`timescale 1ns/1ps
module cfg_regs_bench;
   logic        clk     = 1'b0;
   logic        rst     = 1'b1;
   logic [4:0]  adr     = '0;
   logic        rd_en   = 1'b0;
   logic        wr_en   = 1'b0;
   logic [31:0] wdat    = '0;
   logic [3:0]  ben     = 4'h3;
   logic        sres    = 1'b0;
   logic        dual    = 1'b1;
   logic        wake    = 1'b1;
   logic        sho     = 1'b0;
   logic [2:0]  ext_low = '0;
   logic [31:0] rdat;
   logic        wreq;
   logic        so;
   logic        so_oe;
   logic        spa;
   logic        spb;
   logic        slp;
   logic        mon_oe;
   logic [2:0]  g_out;
   logic [2:0]  g_oe;
   logic [13:0] route;
   wire  [2:0]  g_pin;
   wire         sel_n;
   wire         sclk;
   wire         sdi;
   int          n_mismatch = 0;
   int          n_compared = 0;

   // open-drain pins with pull-ups; the bench may also pull a pin low
   assign g_pin = ~((g_oe & ~g_out) | ext_low);
   always #50 clk = ~clk;

   cfg_regs i_dut (.CLOCK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd_en), .AVS_WRITE(wr_en),
      .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(ben), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
      .SOFT_RESET(sres), .DUAL_SUPPLY(dual), .WAKE_PIN(wake), .SERIAL_SELECT_N(sel_n),
      .SERIAL_CLOCK(sclk), .SERIAL_IN(sdi), .SHIFT_OUT(sho), .SERIAL_OUT(so), .SERIAL_OUT_OE(so_oe),
      .GPIO_IN(g_pin), .GPIO_OUT(g_out), .GPIO_OE(g_oe), .MONITOR_ROUTE(route), .MONITOR_OE(mon_oe),
      .SPAN_A_X4(spa), .SPAN_B_X4(spb), .SLEEP_ACTIVE(slp));
   serial_host_model i_host (.CLOCK(clk), .SELECT_N(sel_n), .SCLK(sclk), .SDI(sdi));

   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic stop_test();
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // request held until the rising edge where waitrequest is seen low; read data are taken at that edge
   task automatic bus_wait(output logic [31:0] data);
      logic w;
      w    = 1'b1;
      data = '0;
      for (int k = 0; k < 40 && w !== 1'b0; k++) begin
         @(posedge clk);
         w    = wreq;
         data = rdat;
      end
      if (w !== 1'b0) begin
         check("waitrequest", {31'h0, w}, 32'h0000_0000);
         stop_test();
      end
   endtask : bus_wait

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [31:0] unused;
      @(posedge clk);
      adr   <= a;
      wdat  <= {16'h0000, d};
      wr_en <= 1'b1;
      bus_wait(unused);
      wr_en <= 1'b0;
   endtask : wr

   task automatic rdc(input string what, input logic [4:0] a, input logic [15:0] exp);
      logic [31:0] got;
      @(posedge clk);
      adr   <= a;
      rd_en <= 1'b1;
      bus_wait(got);
      rd_en <= 1'b0;
      check(what, got, {16'h0000, exp});
   endtask : rdc

   task automatic settle(input int n);
      repeat (n) @(negedge clk);
   endtask : settle

   task automatic do_reset(input logic d);
      @(posedge clk);
      dual <= d;
      rst  <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
   endtask : do_reset

   localparam logic [4:0] A_CFG = {1'b0, cfg_regs_pkg::OFF_CONFIG};
   localparam logic [4:0] A_MON = {1'b0, cfg_regs_pkg::OFF_MONITOR};
   localparam logic [4:0] A_PIN = {1'b0, cfg_regs_pkg::OFF_PINS};
   localparam logic [4:0] A_OA  = {1'b0, cfg_regs_pkg::OFF_OFS_A};
   localparam logic [4:0] A_OB  = cfg_regs_pkg::OFF_OFS_B_W;
   localparam logic [4:0] A_SLP = cfg_regs_pkg::OFF_SLEEP;

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic s_defaults();
      rdc("cfg", A_CFG, 16'h0000);
      rdc("pins", A_PIN, 16'hE000);
      rdc("ofsA", A_OA, 16'h999A);
      rdc("ofsB", A_OB, 16'h999A);
      check("mon_oe", {31'h0, mon_oe}, 32'h0000_0000);
      check("spans", {30'h0, spa, spb}, 32'h0000_0000);
   endtask : s_defaults

   task automatic s_config();
      wr(A_CFG, 16'h01FF);
      rdc("cfg", A_CFG, 16'h01D0);
      check("spans", {30'h0, spa, spb}, 32'h0000_0003);
      rdc("ofsA", A_OA, 16'hAAAB);
      rdc("ofsB", A_OB, 16'hAAAB);
      wr(A_OA, 16'h1234);
      wr(A_OB, 16'h5678);
      wr(A_CFG, 16'h0080);
      rdc("ofsA", A_OA, 16'h999A);
      rdc("ofsB", A_OB, 16'h5678);
      wr(A_CFG, 16'h000F);
      rdc("cfg", A_CFG, 16'h0000);
      rdc("ofsB", A_OB, 16'h999A);
      wr(5'h18, 16'hFFFF);
      rdc("unmapped", 5'h18, 16'h0000);
      // low lane only: the span A bit in the upper lane must keep its value
      ben <= 4'h1;
      wr(A_CFG, 16'h01FF);
      ben <= 4'h3;
      rdc("cfg_lane0", A_CFG, 16'h00D0);
   endtask : s_config

   task automatic s_serial_out();
      wr(A_CFG, 16'h0040);
      i_host.set_lines(1'b0, 1'b0);
      settle(5);
      check("so_oe", {31'h0, so_oe}, 32'h0000_0000);
      wr(A_CFG, 16'h0000);
      sho <= 1'b1;
      settle(5);
      check("so_oe", {31'h0, so_oe}, 32'h0000_0001);
      check("so", {31'h0, so}, 32'h0000_0001);
      i_host.set_lines(1'b1, 1'b0);
      settle(5);
   endtask : s_serial_out

   task automatic s_sleep();
      wr(A_SLP, 16'h8000);
      i_host.set_lines(1'b1, 1'b1);
      settle(5);
      check("so", {30'h0, so, slp}, 32'h0000_0003);
      i_host.set_lines(1'b1, 1'b0);
      settle(5);
      check("so", {31'h0, so}, 32'h0000_0000);
      i_host.frame(0);
      check("slp", {31'h0, slp}, 32'h0000_0001);
      wr(A_CFG, 16'h0010);
      i_host.frame(2);
      check("slp", {31'h0, slp}, 32'h0000_0001);
      i_host.frame(1);
      check("slp", {31'h0, slp}, 32'h0000_0000);
      wr(A_SLP, 16'h8000);
      wake <= 1'b0;
      settle(5);
      check("slp", {31'h0, slp}, 32'h0000_0000);
      wake <= 1'b1;
      wr(A_CFG, 16'h0000);
   endtask : s_sleep

   task automatic s_monitor();
      for (int i = 0; i < 12; i++) begin
         wr(A_MON, 16'h0010 << i);
         settle(3);
         check("route", {17'h0, mon_oe, route}, {17'h0, 1'b1, 14'h0001 << i});
      end
      wr(A_MON, 16'h0030);
      rdc("mon", A_MON, 16'h0030);
      check("mon_oe", {31'h0, mon_oe}, 32'h0000_0000);
      // a valid source first, so that disabling has something to turn off
      wr(A_MON, 16'h0010);
      settle(3);
      check("mon_oe", {31'h0, mon_oe}, 32'h0000_0001);
      wr(A_MON, 16'h0000);
      settle(3);
      check("mon_oe", {17'h0, mon_oe, route}, 32'h0000_0000);
   endtask : s_monitor

   task automatic s_pins();
      wr(A_PIN, 16'hA000);
      settle(3);
      check("g_oe", {29'h0, g_oe}, 32'h0000_0002);
      check("g_out", {29'h0, g_out}, 32'h0000_0000);
      rdc("pins", A_PIN, 16'hA000);
      ext_low <= 3'h4;
      settle(5);
      rdc("pins", A_PIN, 16'h2000);
      ext_low <= 3'h0;
      wr(A_PIN, 16'h0000);
      sres <= 1'b1;
      @(posedge clk);
      sres <= 1'b0;
      settle(5);
      check("g_oe", {29'h0, g_oe}, 32'h0000_0000);
      rdc("pins", A_PIN, 16'hE000);
   endtask : s_pins

   task automatic s_single();
      do_reset(1'b0);
      rdc("ofsA", A_OA, 16'h0000);
      wr(A_OA, 16'h1234);
      wr(A_CFG, 16'h0180);
      rdc("ofsA", A_OA, 16'h0000);
      rdc("ofsB", A_OB, 16'h0000);
   endtask : s_single

   initial begin
      do_reset(1'b1);
      s_defaults();
      s_config();
      s_serial_out();
      s_sleep();
      s_monitor();
      s_pins();
      s_single();
      stop_test();
   end
endmodule : cfg_regs_bench

// *** dv/serial_host_model.sv ***
// serial host model driving select, clock and data toward the register bank
`timescale 1ns/1ps
module serial_host_model (
   input  wire logic CLOCK,
   output logic      SELECT_N,
   output logic      SCLK,
   output logic      SDI
);
   // ************************************************************
   // line control
   // ************************************************************
   // the serial clock rests low between frames
   initial begin
      SELECT_N = 1'b1;
      SCLK     = 1'b0;
      SDI      = 1'b0;
   end

   task automatic set_lines(input logic s_n, input logic d);
      @(posedge CLOCK);
      SELECT_N <= s_n;
      SDI      <= d;
   endtask : set_lines

   // four clocks per phase so the two-stage synchroniser sees every edge
   task automatic frame(input int falls);
      @(posedge CLOCK);
      SELECT_N <= 1'b0;
      repeat (4) @(posedge CLOCK);
      for (int i = 0; i < falls; i++) begin
         SCLK <= 1'b1;
         repeat (4) @(posedge CLOCK);
         SCLK <= 1'b0;
         repeat (4) @(posedge CLOCK);
      end
      SELECT_N <= 1'b1;
      repeat (6) @(posedge CLOCK);
   endtask : frame
endmodule : serial_host_model

// *** rtl/bit_sync.sv ***
// two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module bit_sync #(
   parameter int W = 1
) (
   input  wire logic         CLOCK,
   input  wire logic         RST,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_q;

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         meta_q <= '0;
         dout   <= '0;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule : bit_sync

// *** rtl/cfg_regs.sv ***
// register bank: configuration, monitor select, pin control and offset codes
`timescale 1ns/1ps
// Overview of operation
// - group A span change reloads offset A with the matching trimmed code
// - span A defaults zero: zero is six times reference, one four times
// - group B span change reloads offset B with the matching trimmed code
// - span B defaults zero: zero is six times reference, one four times
// - serial-output disable at one keeps serial output high impedance always
// - no-operation bit has no effect and always reads zero
// - wake bit and high wake pin: select rise ends sleep if at most one clock fall
// - wake bit zero never wakes; low wake pin forces normal mode
// - four lowest configuration bits ignore writes and read zero
// - all-zero monitor selection disables monitor pin to high impedance
// - monitor routes exactly one of twelve sources; two of the fourteen route slots stay unrouted
// - invalid monitor patterns are stored but monitor pin forced high impedance
// - pin bits fifteen to thirteen: one releases, zero drives low
// - pin register reads sampled pin levels, not written values
// - every reset sets pin bits to one, register E000h
// - dual supply loads trimmed offset codes by span; single supply zero
// - single supply ignores offset writes and reads zero
// - four separate trimmed constants, one per register per span
// - sleep bypasses shift path, input to output; cleared by hard reset or low wake, kept by soft reset
module cfg_regs (
   input  wire logic        CLOCK,
   input  wire logic        RST,
   input  wire logic [4:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   input  wire logic        SOFT_RESET,
   input  wire logic        DUAL_SUPPLY,
   input  wire logic        WAKE_PIN,
   input  wire logic        SERIAL_SELECT_N,
   input  wire logic        SERIAL_CLOCK,
   input  wire logic        SERIAL_IN,
   input  wire logic        SHIFT_OUT,
   output logic             SERIAL_OUT,
   output logic             SERIAL_OUT_OE,
   input  wire logic [2:0]  GPIO_IN,
   output logic      [2:0]  GPIO_OUT,
   output logic      [2:0]  GPIO_OE,
   output logic      [13:0] MONITOR_ROUTE,
   output logic             MONITOR_OE,
   output logic             SPAN_A_X4,
   output logic             SPAN_B_X4,
   output logic             SLEEP_ACTIVE
);
   // ************************************************************
   // synchronised pins
   // ************************************************************
   logic [7:0]  sync_in;
   logic [7:0]  sync_out;
   logic        wake_s;
   logic        cs_n_s;
   logic        sclk_s;
   logic        sdi_s;
   logic [2:0]  gpio_s;
   logic        dual_s;

   bit_sync #(
      .W (8)
   ) u_sync (
      .CLOCK (CLOCK),
      .RST   (RST),
      .din   (sync_in),
      .dout  (sync_out)
   );

   // select travels inverted so the synchroniser's reset value reads as deselected: no false rise after reset
   assign sync_in = {DUAL_SUPPLY, GPIO_IN, SERIAL_IN, SERIAL_CLOCK, ~SERIAL_SELECT_N, WAKE_PIN};
   assign wake_s  = sync_out[0];
   assign cs_n_s  = ~sync_out[1];
   assign sclk_s  = sync_out[2];
   assign sdi_s   = sync_out[3];
   assign gpio_s  = sync_out[6:4];
   assign dual_s  = sync_out[7];

   // ************************************************************
   // bus decode
   // ************************************************************
   // single-cycle wait on reads keeps read data registered; writes finish at once
   logic        rd_done_q;
   logic        wr_lo;
   logic        wr_hi;
   logic        wr_cfg;
   logic        wr_mon;
   logic        wr_pin;
   logic        wr_ofa;
   logic        wr_ofb;
   logic        wr_slp;
   logic [15:0] wd;

   assign AVS_WAITREQUEST = AVS_READ & ~rd_done_q;
   assign wr_lo  = AVS_WRITE & AVS_BYTEENABLE[0];
   assign wr_hi  = AVS_WRITE & AVS_BYTEENABLE[1];
   assign wd     = AVS_WRITEDATA[15:0];
   assign wr_cfg = (AVS_ADDRESS == {1'b0, cfg_regs_pkg::OFF_CONFIG});
   assign wr_mon = (AVS_ADDRESS == {1'b0, cfg_regs_pkg::OFF_MONITOR});
   assign wr_pin = (AVS_ADDRESS == {1'b0, cfg_regs_pkg::OFF_PINS});
   assign wr_ofa = (AVS_ADDRESS == {1'b0, cfg_regs_pkg::OFF_OFS_A});
   assign wr_ofb = (AVS_ADDRESS == cfg_regs_pkg::OFF_OFS_B_W);
   assign wr_slp = (AVS_ADDRESS == cfg_regs_pkg::OFF_SLEEP);

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         rd_done_q <= 1'b0;
      end else begin
         rd_done_q <= AVS_READ & ~rd_done_q;
      end
   end

   // ************************************************************
   // supply mode capture
   // ************************************************************
   logic       dual_q;
   logic       dual_seen_q;
   logic [1:0] dual_wait_q;
   logic       soft_q;

   // the flag is taken only once the synchroniser holds the pin's level rather than its reset value
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         dual_q      <= 1'b0;
         dual_seen_q <= 1'b0;
         dual_wait_q <= 2'd0;
      end else if (!dual_seen_q) begin
         if (dual_wait_q == 2'(cfg_regs_pkg::SYNC_STAGES)) begin
            dual_q      <= dual_s;
            dual_seen_q <= 1'b1;
         end else begin
            dual_wait_q <= dual_wait_q + 2'd1;
         end
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         soft_q <= 1'b0;
      end else begin
         soft_q <= SOFT_RESET;
      end
   end

   // ************************************************************
   // configuration register
   // ************************************************************
   logic [15:0] cfg_q;
   logic [15:0] cfg_d;

   // no-operation and reserved bits are masked so they never store
   assign cfg_d = wd & cfg_regs_pkg::CONFIG_MASK & ~(16'h0001 << cfg_regs_pkg::BIT_NOP);

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         cfg_q <= 16'h0000;
      end else if (soft_q) begin
         cfg_q <= 16'h0000;
      end else if (wr_cfg && wr_lo && wr_hi) begin
         cfg_q <= cfg_d;
      end else if (wr_cfg && wr_lo) begin
         cfg_q <= {cfg_q[15:8], cfg_d[7:0]};
      end else if (wr_cfg && wr_hi) begin
         cfg_q <= {cfg_d[15:8], cfg_q[7:0]};
      end
   end

   assign SPAN_A_X4 = cfg_q[cfg_regs_pkg::BIT_GAIN_A];
   assign SPAN_B_X4 = cfg_q[cfg_regs_pkg::BIT_GAIN_B];

   // ************************************************************
   // offset code registers
   // ************************************************************
   logic        span_a_last_q;
   logic        span_b_last_q;
   logic        init_q;
   logic [15:0] ofs_a_q;
   logic [15:0] ofs_b_q;
   logic [15:0] trim_a;
   logic [15:0] trim_b;

   assign trim_a = SPAN_A_X4 ? cfg_regs_pkg::TRIM_A_X4 : cfg_regs_pkg::TRIM_A_X6;
   assign trim_b = SPAN_B_X4 ? cfg_regs_pkg::TRIM_B_X4 : cfg_regs_pkg::TRIM_B_X6;

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         span_a_last_q <= 1'b0;
         span_b_last_q <= 1'b0;
         init_q        <= 1'b1;
      end else begin
         span_a_last_q <= SPAN_A_X4;
         span_b_last_q <= SPAN_B_X4;
         init_q        <= soft_q | ~dual_seen_q;
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         ofs_a_q <= cfg_regs_pkg::ZERO_CODE;
      end else if (!dual_q) begin
         ofs_a_q <= cfg_regs_pkg::ZERO_CODE;
      end else if (init_q || SPAN_A_X4 != span_a_last_q) begin
         ofs_a_q <= trim_a;
      end else if (AVS_WRITE && wr_ofa) begin
         ofs_a_q <= {AVS_BYTEENABLE[1] ? wd[15:8] : ofs_a_q[15:8], AVS_BYTEENABLE[0] ? wd[7:0] : ofs_a_q[7:0]};
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         ofs_b_q <= cfg_regs_pkg::ZERO_CODE;
      end else if (!dual_q) begin
         ofs_b_q <= cfg_regs_pkg::ZERO_CODE;
      end else if (init_q || SPAN_B_X4 != span_b_last_q) begin
         ofs_b_q <= trim_b;
      end else if (AVS_WRITE && wr_ofb) begin
         ofs_b_q <= {AVS_BYTEENABLE[1] ? wd[15:8] : ofs_b_q[15:8], AVS_BYTEENABLE[0] ? wd[7:0] : ofs_b_q[7:0]};
      end
   end

   // ************************************************************
   // monitor select
   // ************************************************************
   logic [15:0] mon_q;
   logic [13:0] mon_route;
   logic        mon_valid;

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         mon_q <= cfg_regs_pkg::MONITOR_RST;
      end else if (soft_q) begin
         mon_q <= cfg_regs_pkg::MONITOR_RST;
      end else if (AVS_WRITE && wr_mon) begin
         mon_q <= {AVS_BYTEENABLE[1] ? wd[15:8] : mon_q[15:8], AVS_BYTEENABLE[0] ? wd[7:0] : mon_q[7:0]};
      end
   end

   mon_decode u_mon (
      .sel    (mon_q[15:cfg_regs_pkg::MON_LSB]),
      .route  (mon_route),
      .enable (mon_valid)
   );

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         MONITOR_ROUTE <= '0;
         MONITOR_OE    <= 1'b0;
      end else begin
         MONITOR_ROUTE <= mon_route;
         MONITOR_OE    <= mon_valid;
      end
   end

   // ************************************************************
   // general pins
   // ************************************************************
   logic [2:0] pin_q;

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         pin_q <= cfg_regs_pkg::PINS_REL;
      end else if (soft_q) begin
         pin_q <= cfg_regs_pkg::PINS_REL;
      end else if (wr_pin && wr_hi) begin
         pin_q <= wd[15:cfg_regs_pkg::PIN_LSB];
      end
   end

   assign GPIO_OUT = 3'b000;
   assign GPIO_OE  = ~pin_q;

   // ************************************************************
   // serial sleep and wake
   // ************************************************************
   logic sleep_q;
   logic cs_n_last_q;
   logic sclk_last_q;
   logic [1:0] falls_q;
   logic cs_rise;

   assign cs_rise = cs_n_s & ~cs_n_last_q;

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         cs_n_last_q <= 1'b1;
         sclk_last_q <= 1'b0;
         falls_q     <= 2'd0;
      end else begin
         cs_n_last_q <= cs_n_s;
         sclk_last_q <= sclk_s;
         if (cs_n_s) begin
            falls_q <= 2'd0;
         end else if (sclk_last_q && !sclk_s && falls_q != 2'd2) begin
            falls_q <= falls_q + 2'd1;
         end
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         sleep_q <= 1'b0;
      end else if (!wake_s) begin
         sleep_q <= 1'b0;
      end else if (AVS_WRITE && wr_slp && wr_hi) begin
         sleep_q <= wd[cfg_regs_pkg::BIT_SLEEP];
      end else if (cs_rise && cfg_q[cfg_regs_pkg::BIT_CS_WAKE] && falls_q < 2'd2) begin
         sleep_q <= 1'b0;
      end
   end

   assign SLEEP_ACTIVE  = sleep_q;
   assign SERIAL_OUT    = sleep_q ? sdi_s : SHIFT_OUT;
   assign SERIAL_OUT_OE = ~cfg_q[cfg_regs_pkg::BIT_SO_DIS] & (sleep_q | ~cs_n_s);

   // ************************************************************
   // read data
   // ************************************************************
   logic [15:0] rd_mux;

   always_comb begin
      rd_mux = 16'h0000;
      if (AVS_ADDRESS == {1'b0, cfg_regs_pkg::OFF_CONFIG}) begin
         rd_mux = cfg_q;
      end else if (AVS_ADDRESS == {1'b0, cfg_regs_pkg::OFF_MONITOR}) begin
         rd_mux = mon_q;
      end else if (AVS_ADDRESS == {1'b0, cfg_regs_pkg::OFF_PINS}) begin
         rd_mux = {gpio_s, 13'h0000};
      end else if (AVS_ADDRESS == {1'b0, cfg_regs_pkg::OFF_OFS_A}) begin
         rd_mux = ofs_a_q;
      end else if (AVS_ADDRESS == cfg_regs_pkg::OFF_OFS_B_W) begin
         rd_mux = ofs_b_q;
      end else if (AVS_ADDRESS == cfg_regs_pkg::OFF_SLEEP) begin
         rd_mux = {sleep_q, 15'h0000};
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         AVS_READDATA <= 32'h0000_0000;
      end else if (AVS_READ) begin
         AVS_READDATA <= {16'h0000, rd_mux};
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   a_nop_reads_zero: assert property (@(posedge CLOCK) disable iff (RST) !cfg_q[cfg_regs_pkg::BIT_NOP])
      else $error("no-operation bit stored");
   a_reserved_zero: assert property (@(posedge CLOCK) disable iff (RST) cfg_q[3:0] == 4'h0)
      else $error("reserved bits stored");
   a_span_a_reload: assert property (@(posedge CLOCK) disable iff (RST)
      (dual_q && $changed(SPAN_A_X4)) |=> ofs_a_q == $past(trim_a)) else $error("offset A not reloaded");
   a_span_b_reload: assert property (@(posedge CLOCK) disable iff (RST)
      (dual_q && $changed(SPAN_B_X4)) |=> ofs_b_q == $past(trim_b)) else $error("offset B not reloaded");
   a_single_zero: assert property (@(posedge CLOCK) disable iff (RST)
      ##1 !$past(dual_q) |-> ofs_a_q == 16'h0000 && ofs_b_q == 16'h0000) else $error("offset nonzero in single supply");
   a_monitor_off: assert property (@(posedge CLOCK) disable iff (RST)
      mon_q[15:4] == 12'h000 |=> !MONITOR_OE) else $error("monitor driven while disabled");
   a_so_disabled: assert property (@(posedge CLOCK) disable iff (RST)
      cfg_q[cfg_regs_pkg::BIT_SO_DIS] |-> !SERIAL_OUT_OE) else $error("serial out driven while disabled");
   a_pin_drive: assert property (@(posedge CLOCK) disable iff (RST)
      (AVS_WRITE && wr_pin && wr_hi && !soft_q) |=> GPIO_OE == ~$past(wd[15:cfg_regs_pkg::PIN_LSB]) && GPIO_OUT == 3'b000)
      else $error("pin drive mismatch");
   a_wake_low: assert property (@(posedge CLOCK) disable iff (RST) !wake_s |=> !sleep_q)
      else $error("sleep held with wake pin low");
endmodule : cfg_regs

// *** rtl/cfg_regs_pkg.sv ***
// constants for the converter configuration, monitor, pin and offset register bank
package cfg_regs_pkg;
   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [3:0] OFF_CONFIG  = 4'h0;
   localparam logic [3:0] OFF_MONITOR = 4'h4;
   localparam logic [3:0] OFF_PINS    = 4'h8;
   localparam logic [3:0] OFF_OFS_A   = 4'hC;
   localparam logic [3:0] OFF_OFS_B   = 4'h0;
   localparam logic [4:0] OFF_OFS_B_W = 5'h10;
   localparam logic [4:0] OFF_SLEEP   = 5'h14;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int BIT_GAIN_A   = 8;
   localparam int BIT_GAIN_B   = 7;
   localparam int BIT_SO_DIS   = 6;
   localparam int BIT_NOP      = 5;
   localparam int BIT_CS_WAKE  = 4;
   localparam int BIT_SLEEP    = 15;
   localparam int PIN_LSB      = 13;
   localparam int MON_LSB      = 4;

   // ************************************************************
   // reset values and trimmed codes
   // ************************************************************
   localparam logic [15:0] CONFIG_MASK  = 16'h01F0;
   localparam logic [15:0] MONITOR_RST  = 16'h0000;
   localparam logic [15:0] PINS_RST     = 16'hE000;
   localparam logic [15:0] ZERO_CODE    = 16'h0000;
   localparam logic [15:0] TRIM_A_X6    = 16'h999A;
   localparam logic [15:0] TRIM_A_X4    = 16'hAAAB;
   localparam logic [15:0] TRIM_B_X6    = 16'h999A;
   localparam logic [15:0] TRIM_B_X4    = 16'hAAAB;
   localparam logic [2:0]  PINS_REL     = 3'h7;
   localparam int          SYNC_STAGES  = 2;
endpackage : cfg_regs_pkg

// *** rtl/mon_decode.sv ***
// monitor selection decode into a one-hot source select
`timescale 1ns/1ps
module mon_decode (
   input  wire logic [11:0] sel,
   output logic      [13:0] route,
   output logic             enable
);
   // each documented pattern is a single bit in the upper twelve selection bits;
   // source slots beyond the twelve bits are left unrouted until the full table is known
   always_comb begin
      route  = '0;
      enable = 1'b0;
      for (int i = 0; i < 12; i++) begin
         if (sel == (12'h001 << i)) begin
            route[i] = 1'b1;
            enable   = 1'b1;
         end
      end
   end
endmodule : mon_decode
